// ==== include/sst_params.svh ====
`ifndef SST_PARAMS_SVH
`define SST_PARAMS_SVH

// register byte offsets on the apb window
`define SST_ADDR_CTRL     12'h000
`define SST_ADDR_STATE    12'h004
`define SST_ADDR_COUNT    12'h008
`define SST_ADDR_OUTDIR   12'h00c
`define SST_ADDR_OUTPUT   12'h010
// per-event pair: state enable mask at +0, event control at +4
`define SST_BASE_EVMASK   12'h100
`define SST_BASE_EVENT_CONTROL   12'h104
`define SST_EV_STRIDE     8
// capture select and capture value banks
`define SST_BASE_CAPSEL   12'h200
`define SST_BASE_CAPVAL   12'h280
`define SST_CAP_STRIDE    4
// per-output pair: set mask at +0, clear mask at +4
`define SST_BASE_OUTSET   12'h300
`define SST_BASE_OUTCLR   12'h304
`define SST_OUT_STRIDE    8

// control register: low half at bit 0, high half at this bit
`define SST_CTRL_HI_LSB   16
`define SST_CFG_W         12
`define SST_PRE_W         8
// capture select: counter choice bit
`define SST_CAPSEL_HIGH   16
// output direction codes
`define SST_DIR_NONE      2'h0
`define SST_DIR_LOW       2'h1
`define SST_DIR_HIGH      2'h2

// reset values: counters frozen, state zero
`define SST_CFG_RESET     12'h002
`define SST_STATE_RESET   5'h00

`endif

// ==== include/sst_pkg.sv ====
`include "sst_params.svh"
package sst_pkg;

  // one counter half of the control register, bit 0 first from the right
  typedef struct packed {
    logic [`SST_PRE_W-1:0] prescale;  // divide by prescale+1
    logic                  updown;    // low or high counter up/down mode
    logic                  clear;     // self-clearing counter reset
    logic                  freeze;    // hard stop, software only
    logic                  pause;     // soft stop, events may release
  } sst_ctr_cfg_t;

  // event control word
  typedef struct packed {
    logic [3:0] in_sel;        // input that triggers the event
    logic       stop;          // event pauses its counter
    logic       start;         // event releases its counter's pause
    logic       high;          // event belongs to the high counter
    logic       state_load_select;  // 1 replaces the state, 0 adds
    logic [4:0] next_state_value;
  } sst_event_control_t;

endpackage : sst_pkg

// ==== rtl/sst_counter.sv ====
`timescale 1ns/10ps
`include "sst_params.svh"
////////////////////////////////////////////////////////////////////////////////
// one counter half: prescaler, pause, freeze and up/down turnaround
module sst_counter #(
  parameter int CW = 16                        // counter width
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // configuration taken from the control register
  input  wire sst_pkg::sst_ctr_cfg_t cfg,
  // counter state
  output logic [CW-1:0]              count,
  output logic                       down
);

  logic [`SST_PRE_W-1:0] pre;                  // prescale divider
  logic [`SST_PRE_W-1:0] next_pre;
  logic [CW-1:0]         next_count;
  logic                  next_down;
  logic                  run;                  // neither paused nor frozen
  logic                  tick;                 // one-cycle prescaled enable

  // refuse widths the count register cannot show
  if (CW < 2 || CW > 16) begin : g_bad_cw
    $error("sst_counter: CW must lie in 2..16");
  end

  //////////////////////////////////////////////////////////////////////////////
  // next count: clear first, then advance on the prescaled tick
  always_comb begin
    next_pre   = pre;
    next_count = count;
    next_down  = down;
    run        = !cfg.freeze && !cfg.pause;
    tick       = (pre == cfg.prescale);
    if (cfg.clear) begin
      // software clear resets everything
      next_pre   = '0;
      next_count = '0;
      next_down  = 1'b0;
    end else if (run) begin
      if (!tick) begin
        next_pre = pre + `SST_PRE_W'(1);
      end else begin
        next_pre = '0;
        if (!cfg.updown) begin
          // unidirectional: wrap at the top
          next_count = count + CW'(1);
        end else if (!down) begin
          // bidirectional: turn round at the top
          if (count == '1) begin
            next_down  = 1'b1;
            next_count = count - CW'(1);
          end else begin
            next_count = count + CW'(1);
          end
        end else if (count == '0) begin
          // bidirectional: turn round at zero
          next_down  = 1'b0;
          next_count = count + CW'(1);
        end else begin
          next_count = count - CW'(1);
        end
      end
    end
  end

  // register the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre   <= '0;
      count <= '0;
      down  <= 1'b0;
    end else begin
      pre   <= next_pre;
      count <= next_count;
      down  <= next_down;
    end
  end

endmodule : sst_counter

// ==== rtl/sst_timer.sv ====
`timescale 1ns/10ps
`include "sst_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - events occur only in their enabled states
// - highest occurring event adds or loads state
// - zero value and add mode keep state
// - captures latch counter on any assigned event
// - direction control swaps output set and clear
// - state starts zero, software may write it
// - counter runs only while pause bit clear
// - per-counter up/down mode in control register
// - prescaler divides counter clock from control
// - reset leaves both counters frozen, no events
// - software stops counters via pause or freeze
// - start event or software clears the pause
module sst_timer #(
  parameter int N_EV  = 16,                    // number of events
  parameter int N_CAP = 8,                     // number of capture registers
  parameter int N_OUT = 8,                     // number of outputs
  parameter int N_IN  = 8,                     // number of event inputs
  parameter int CW    = 16                     // width of each counter half
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // event inputs and outputs
  input  wire logic [N_IN-1:0]  ev_in,
  output logic      [N_OUT-1:0] out_o
);

  // refuse sizes the register map cannot serve
  if (N_EV < 1 || N_EV > 16 || N_CAP < 1 || N_CAP > 32 || N_OUT < 1 || N_OUT > 16 ||
      N_IN < 1 || N_IN > 16) begin : g_bad_size
    $error("sst_timer: parameter out of range");
  end

  sst_pkg::sst_ctr_cfg_t        cfg [2];       // 0 low counter, 1 high counter
  sst_pkg::sst_ctr_cfg_t        next_cfg [2];
  logic [4:0]                   state;         // current timer state
  logic [4:0]                   next_state;
  logic [31:0]                  ev_mask [N_EV];       // event_state_enable_mask
  logic [31:0]                  next_ev_mask [N_EV];
  sst_pkg::sst_event_control_t  ev_ctrl [N_EV];       // event_control
  sst_pkg::sst_event_control_t  next_ev_ctrl [N_EV];
  logic [16:0]                  cap_sel [N_CAP];      // event mask and counter choice
  logic [16:0]                  next_cap_sel [N_CAP];
  logic [CW-1:0]                cap_val [N_CAP];      // captured counts
  logic [CW-1:0]                next_cap_val [N_CAP];
  logic [N_EV-1:0]              out_set [N_OUT];      // events that set an output
  logic [N_EV-1:0]              next_out_set [N_OUT];
  logic [N_EV-1:0]              out_clr [N_OUT];      // events that clear an output
  logic [N_EV-1:0]              next_out_clr [N_OUT];
  logic [2*N_OUT-1:0]           out_dir;              // output_direction_control
  logic [2*N_OUT-1:0]           next_out_dir;
  logic [N_OUT-1:0]             next_out;
  logic [31:0]                  next_prdata;
  logic                         next_pready;
  logic                         next_pslverr;
  logic                         wr_en;         // write takes effect this edge
  logic [CW-1:0]                cnt [2];       // counter values
  logic [1:0]                   down;          // counting down flags
  logic [15:0]                  in_pad;        // inputs padded to 16
  logic [N_EV-1:0]              ev_act;        // events occurring this cycle
  logic                         win_found;     // some event occurs
  logic [3:0]                   win;           // highest occurring event

  // byte address of entry idx in a bank
  function automatic logic [11:0] reg_at(input logic [11:0] base, input int idx,
                                         input int stride);
    reg_at = base + 12'(idx * stride);
  endfunction : reg_at

  //////////////////////////////////////////////////////////////////////////////
  // the two counter halves
  for (genvar c = 0; c < 2; c++) begin : g_ctr
    sst_counter #(
      .CW (CW)
    ) u_ctr (
      .pclk    (pclk),
      .presetn (presetn),
      .cfg     (cfg[c]),
      .count   (cnt[c]),
      .down    (down[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // event qualification and priority
  always_comb begin
    in_pad    = 16'(ev_in);
    ev_act    = '0;
    win_found = 1'b0;
    win       = 4'h0;
    for (int e = 0; e < N_EV; e++) begin
      // enabled in this state, counter not frozen, input high
      ev_act[e] = ev_mask[e][state] && !cfg[ev_ctrl[e].high].freeze
                  && in_pad[ev_ctrl[e].in_sel];
      if (ev_act[e]) begin
        win_found = 1'b1;
        win       = 4'(e);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb write strobe: only at the edge that sees pready
  assign wr_en = psel && penable && pready && pwrite;

  // next configuration, state and event tables
  always_comb begin
    next_cfg     = cfg;
    next_state   = state;
    next_ev_mask = ev_mask;
    next_ev_ctrl = ev_ctrl;
    next_cap_sel = cap_sel;
    next_out_set = out_set;
    next_out_clr = out_clr;
    next_out_dir = out_dir;
    next_cfg[0].clear = 1'b0;                  // clear is a one-cycle pulse
    next_cfg[1].clear = 1'b0;
    if (wr_en) begin
      if (paddr == `SST_ADDR_CTRL) begin
        // pause, freeze, mode and prescale per half
        next_cfg[0] = sst_pkg::sst_ctr_cfg_t'(pwdata[`SST_CFG_W-1:0]);
        next_cfg[1] = sst_pkg::sst_ctr_cfg_t'(pwdata[`SST_CTRL_HI_LSB +: `SST_CFG_W]);
      end
      if (paddr == `SST_ADDR_STATE) next_state = pwdata[4:0];
      if (paddr == `SST_ADDR_OUTDIR) next_out_dir = pwdata[2*N_OUT-1:0];
      for (int e = 0; e < N_EV; e++) begin
        if (paddr == reg_at(`SST_BASE_EVMASK, e, `SST_EV_STRIDE)) next_ev_mask[e] = pwdata;
        if (paddr == reg_at(`SST_BASE_EVENT_CONTROL, e, `SST_EV_STRIDE))
          next_ev_ctrl[e] = sst_pkg::sst_event_control_t'(pwdata[12:0]);
      end
      for (int n = 0; n < N_CAP; n++) begin
        if (paddr == reg_at(`SST_BASE_CAPSEL, n, `SST_CAP_STRIDE)) next_cap_sel[n] = pwdata[16:0];
      end
      for (int o = 0; o < N_OUT; o++) begin
        if (paddr == reg_at(`SST_BASE_OUTSET, o, `SST_OUT_STRIDE))
          next_out_set[o] = pwdata[N_EV-1:0];
        if (paddr == reg_at(`SST_BASE_OUTCLR, o, `SST_OUT_STRIDE))
          next_out_clr[o] = pwdata[N_EV-1:0];
      end
    end
    // events act on pause after software, so a hardware change wins
    for (int e = 0; e < N_EV; e++) begin
      if (ev_act[e] && ev_ctrl[e].start) next_cfg[ev_ctrl[e].high].pause = 1'b0;
      if (ev_act[e] && ev_ctrl[e].stop)  next_cfg[ev_ctrl[e].high].pause = 1'b1;
    end
    // the highest occurring event steers the state
    if (win_found) begin
      if (ev_ctrl[win].next_state_value == 5'h00 && !ev_ctrl[win].state_load_select) begin
        next_state = state;
      end else if (ev_ctrl[win].state_load_select) begin
        next_state = ev_ctrl[win].next_state_value;
      end else begin
        next_state = state + ev_ctrl[win].next_state_value;
      end
    end
  end

  // register configuration, state and tables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg[0]  <= sst_pkg::sst_ctr_cfg_t'(`SST_CFG_RESET);
      cfg[1]  <= sst_pkg::sst_ctr_cfg_t'(`SST_CFG_RESET);
      state   <= `SST_STATE_RESET;
      out_dir <= '0;
      for (int e = 0; e < N_EV; e++) begin
        ev_mask[e] <= '0;
        ev_ctrl[e] <= '0;
      end
      for (int n = 0; n < N_CAP; n++) cap_sel[n] <= '0;
      for (int o = 0; o < N_OUT; o++) begin
        out_set[o] <= '0;
        out_clr[o] <= '0;
      end
    end else begin
      cfg     <= next_cfg;
      state   <= next_state;
      ev_mask <= next_ev_mask;
      ev_ctrl <= next_ev_ctrl;
      cap_sel <= next_cap_sel;
      out_set <= next_out_set;
      out_clr <= next_out_clr;
      out_dir <= next_out_dir;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // captures and outputs
  always_comb begin
    next_cap_val = cap_val;
    next_out     = out_o;
    for (int n = 0; n < N_CAP; n++) begin
      // any assigned event latches the chosen counter
      if (|(ev_act & cap_sel[n][N_EV-1:0]))
        next_cap_val[n] = cnt[cap_sel[n][`SST_CAPSEL_HIGH]];
    end
    for (int o = 0; o < N_OUT; o++) begin
      logic set_o;
      logic clr_o;
      logic swap;
      set_o = |(ev_act & out_set[o]);
      clr_o = |(ev_act & out_clr[o]);
      // while the chosen bidirectional counter runs down, set and clear trade places;
      // a down flag left over from an earlier bidirectional run must not swap
      swap  = (out_dir[2*o +: 2] == `SST_DIR_LOW && cfg[0].updown && down[0]) ||
              (out_dir[2*o +: 2] == `SST_DIR_HIGH && cfg[1].updown && down[1]);
      if (swap ? clr_o : set_o) next_out[o] = 1'b1;
      else if (swap ? set_o : clr_o) next_out[o] = 1'b0;
    end
  end

  // register captures and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < N_CAP; n++) cap_val[n] <= '0;
      out_o <= '0;
    end else begin
      cap_val <= next_cap_val;
      out_o   <= next_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb read data and answer, one wait state
  always_comb begin
    next_pready  = psel && penable && !pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (next_pready) begin
      logic        hit;
      logic [31:0] rd;
      hit = 1'b1;
      rd  = '0;
      case (paddr)
        `SST_ADDR_CTRL: begin
          rd[`SST_CFG_W-1:0] = cfg[0];
          rd[`SST_CTRL_HI_LSB +: `SST_CFG_W] = cfg[1];
        end
        `SST_ADDR_STATE:  rd[4:0] = state;
        `SST_ADDR_COUNT:  rd = {16'(cnt[1]), 16'(cnt[0])};
        `SST_ADDR_OUTDIR: rd[2*N_OUT-1:0] = out_dir;
        `SST_ADDR_OUTPUT: rd[N_OUT-1:0] = out_o;
        default: begin
          hit = 1'b0;
          for (int e = 0; e < N_EV; e++) begin
            if (paddr == reg_at(`SST_BASE_EVMASK, e, `SST_EV_STRIDE)) begin
              hit = 1'b1;
              rd  = ev_mask[e];
            end
            if (paddr == reg_at(`SST_BASE_EVENT_CONTROL, e, `SST_EV_STRIDE)) begin
              hit = 1'b1;
              rd  = 32'(ev_ctrl[e]);
            end
          end
          for (int n = 0; n < N_CAP; n++) begin
            if (paddr == reg_at(`SST_BASE_CAPSEL, n, `SST_CAP_STRIDE)) begin
              hit = 1'b1;
              rd  = 32'(cap_sel[n]);
            end
            if (paddr == reg_at(`SST_BASE_CAPVAL, n, `SST_CAP_STRIDE)) begin
              hit = 1'b1;
              rd  = 32'(cap_val[n]);
            end
          end
          for (int o = 0; o < N_OUT; o++) begin
            if (paddr == reg_at(`SST_BASE_OUTSET, o, `SST_OUT_STRIDE)) begin
              hit = 1'b1;
              rd  = 32'(out_set[o]);
            end
            if (paddr == reg_at(`SST_BASE_OUTCLR, o, `SST_OUT_STRIDE)) begin
              hit = 1'b1;
              rd  = 32'(out_clr[o]);
            end
          end
        end
      endcase
      next_prdata  = pwrite ? 32'h0000_0000 : rd;
      next_pslverr = !hit;                     // unmapped address
    end
  end

  // register the apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mask_gate_a: assert property (win_found |-> ev_mask[win][state])
    else $error("winning event not enabled in current state");
  load_state_a: assert property (win_found && ev_ctrl[win].state_load_select
                                 |=> state == $past(ev_ctrl[win].next_state_value))
    else $error("load event did not replace state");
  zero_hold_a: assert property (win_found && !ev_ctrl[win].state_load_select &&
                                ev_ctrl[win].next_state_value == 5'h00 |=> $stable(state))
    else $error("zero event changed state");
  capture_latch_a: assert property ((|(ev_act & cap_sel[0][N_EV-1:0]))
                                    |=> cap_val[0] == $past(cnt[cap_sel[0][16]]))
    else $error("capture missed counter value");
  frozen_quiet_a: assert property (cfg[0].freeze && cfg[1].freeze |-> ev_act == '0)
    else $error("event occurred while frozen");
  freeze_hold_a: assert property (cfg[0].freeze && !(wr_en && paddr == `SST_ADDR_CTRL)
                                  |=> cfg[0].freeze)
    else $error("freeze released without software");
  paused_still_a: assert property ((cfg[0].pause && !cfg[0].clear) [*2]
                                   |-> $stable(cnt[0]))
    else $error("paused counter moved");
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not exactly one wait state");

endmodule : sst_timer

// ==== tb/sst_timer_bench.sv ====
`timescale 1ns/10ps
`include "sst_params.svh"
////////////////////////////////////////////////////////////////////////////////
// register-level bench: apb tasks plus event input drive
module sst_timer_bench;
  logic        pclk;      // bus clock
  logic        presetn;   // async reset, active low
  logic        psel;      // apb select
  logic        penable;   // apb access phase
  logic        pwrite;    // apb direction
  logic [11:0] paddr;     // apb byte address
  logic [31:0] pwdata;    // apb write data
  logic [31:0] prdata;    // apb read data
  logic        pready;    // apb ready
  logic        pslverr;   // apb error
  logic [7:0]  ev_in;     // event inputs
  logic [7:0]  out_o;     // timer outputs
  int          n_errors;  // mismatches seen
  int          compares;  // comparisons made
  int          cycles;    // timeout counter
  logic [31:0] c1;        // count held while paused
  logic [31:0] rv;        // scratch read value
  logic        re;        // scratch error flag

  ////////////////////////////////////////////////////////////////////////////////
  // device under test, short counters so the bidirectional turnaround comes quickly
  sst_timer #(
    .CW (4)
  ) sst_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_in(ev_in), .out_o(out_o)
  );

  // 125 mhz clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // hang guard: a runaway run is cut short and fails
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // closing verdict
  task automatic final_report();
    $display("errors %0d of %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // compare a data word
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  // compare a one-bit flag
  task automatic chk_flag(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  // one apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local timeout: if pready never rises, only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, re);
  endtask : wr

  // register read with check
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rv, re);
    chk_data(rv, exp);
  endtask : rd

  // event input drive, two edges for the update to land
  task automatic drive_in(input logic [7:0] v);
    @(posedge pclk);
    ev_in <= v;
    repeat (2) @(posedge pclk);
  endtask : drive_in

  // event input pulse lasting exactly one cycle
  task automatic pulse_in(input logic [7:0] v);
    @(posedge pclk);
    ev_in <= v;
    @(posedge pclk);
    ev_in <= 8'h00;
  endtask : pulse_in

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; ev_in = 8'h00;
    n_errors = 0; compares = 0; cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SST_ADDR_CTRL, 32'h0002_0002);
    rd(`SST_ADDR_STATE, 32'h0000_0000);
    apb(1'b0, 12'hffc, 32'h0000_0000, rv, re);
    chk_flag(re, 1'b1);
    wr(`SST_ADDR_STATE, 32'h0000_0005);
    rd(`SST_ADDR_STATE, 32'h0000_0005);
    // ev0 loads 9 in state 5; ev1 loads 3, ev2 adds 4 in state 9; ev3 is null in 13
    wr(12'h100, 32'h0000_0020); wr(12'h104, 32'h0000_0029);
    wr(12'h108, 32'h0000_0200); wr(12'h10c, 32'h0000_0223);
    wr(12'h110, 32'h0000_0200); wr(12'h114, 32'h0000_0204);
    wr(12'h118, 32'h0000_2000); wr(12'h11c, 32'h0000_0200);
    // ev4 feeds capture 0, ev5 starts the low counter
    wr(12'h120, 32'hffff_ffff); wr(12'h124, 32'h0000_0400);
    wr(12'h128, 32'hffff_ffff); wr(12'h12c, 32'h0000_0680);
    wr(`SST_BASE_CAPSEL, 32'h0000_0010);
    drive_in(8'h01);
    rd(`SST_ADDR_STATE, 32'h0000_0005);
    rd(`SST_ADDR_CTRL, 32'h0002_0002);
    wr(`SST_ADDR_CTRL, 32'h0001_0001);
    rd(`SST_ADDR_STATE, 32'h0000_0009);
    drive_in(8'h00);
    drive_in(8'h02);
    rd(`SST_ADDR_STATE, 32'h0000_000d);
    drive_in(8'h00);
    rd(`SST_ADDR_STATE, 32'h0000_000d);
    rd(`SST_ADDR_COUNT, 32'h0000_0000);
    // one start pulse releases the low pause only
    pulse_in(8'h08);
    rd(`SST_ADDR_CTRL, 32'h0001_0000);
    wr(`SST_ADDR_CTRL, 32'h0001_0001);
    apb(1'b0, `SST_ADDR_COUNT, 32'h0000_0000, c1, re);
    chk_flag(c1 != 32'h0000_0000, 1'b1);
    rd(`SST_ADDR_COUNT, c1);
    drive_in(8'h04);
    drive_in(8'h00);
    rd(`SST_BASE_CAPVAL, c1);
    rd(`SST_ADDR_STATE, 32'h0000_000d);
    // software zero on the pause bit resumes counting
    wr(`SST_ADDR_CTRL, 32'h0001_0000);
    apb(1'b0, `SST_ADDR_COUNT, 32'h0000_0000, rv, re);
    chk_flag(rv != c1, 1'b1);
    // high counter at prescale 3 moves once in the four cycles between two reads
    wr(`SST_ADDR_CTRL, 32'h0030_0001);
    apb(1'b0, `SST_ADDR_COUNT, 32'h0000_0000, c1, re);
    rd(`SST_ADDR_COUNT, c1 + 32'h0001_0000);
    // ev6 on input 4 sets output 0; it swaps while the low counter runs down
    wr(12'h130, 32'hffff_ffff); wr(12'h134, 32'h0000_0800);
    wr(`SST_BASE_OUTSET, 32'h0000_0040);
    wr(`SST_ADDR_OUTDIR, 32'h0000_0001);
    // low counter cleared and bidirectional, high counter paused
    wr(`SST_ADDR_CTRL, 32'h0001_000c);
    pulse_in(8'h10);
    rd(`SST_ADDR_OUTPUT, 32'h0000_0001);
    chk_flag(out_o[0], 1'b1);
    // wait until the low counter has turned round at the top
    repeat (12) @(posedge pclk);
    pulse_in(8'h10);
    apb(1'b0, `SST_ADDR_COUNT, 32'h0000_0000, c1, re);
    rd(`SST_ADDR_COUNT, c1 - 32'h0000_0004);
    rd(`SST_ADDR_OUTPUT, 32'h0000_0000);
    chk_flag(out_o[0], 1'b0);
    final_report();
  end
endmodule : sst_timer_bench
